// >>> logic/sfl_pkg.sv
package sfl_pkg;

	// Line symbols; primitives travel with the k flag set
	typedef enum logic [3:0] {
		P_SYNC, P_X_RDY, P_R_RDY, P_SOF, P_R_IP, P_HOLD, P_HOLDA,
		P_DMAT, P_EOF, P_WTRM, P_R_OK, P_R_ERR
	} prim_t;

	localparam logic [31:0] CRC_SEED = 32'h52325032;
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
	localparam int DW_CNT_W = 12;
	localparam logic [DW_CNT_W-1:0] MAX_FRAME_DW = 12'h810;
	localparam logic [DW_CNT_W-1:0] CNT_RESET = 12'h000;
	localparam logic [31:0] WORD_RESET = 32'h00000000;
	localparam logic [15:0] PAD_HALF = 16'h0000;

endpackage : sfl_pkg

// >>> logic/sfl_link_if.sv
`timescale 1ns/1ps
interface sfl_link_if
	import sfl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst
);
	logic h2d_k;
	prim_t h2d_prim;
	logic [31:0] h2d_data;
	prim_t d2h_prim;

	modport host (
		output h2d_k,
		output h2d_prim,
		output h2d_data,
		input d2h_prim
	);

	modport dev (
		input h2d_k,
		input h2d_prim,
		input h2d_data,
		output d2h_prim
	);
endinterface : sfl_link_if

// >>> logic/sfl_crc32.sv
`timescale 1ns/1ps
module sfl_crc32
	import sfl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic init,
	input wire logic en,
	input wire logic [31:0] data,
	output logic [31:0] crc_ff
);
	// Whole DWORD in one clock, MSB first
	function automatic logic [31:0] crc_step(input logic [31:0] c,
		input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			if (r[31] ^ d[i]) begin
				r = {r[30:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[30:0], 1'b0};
			end
		end
		return r;
	endfunction : crc_step

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			crc_ff <= CRC_SEED;
		end else if (init) begin
			crc_ff <= CRC_SEED;
		end else if (en) begin
			crc_ff <= crc_step(crc_ff, data);
		end
	end
endmodule : sfl_crc32

// >>> logic/sfl_dev_end.sv
`timescale 1ns/1ps
// What this block and sfl_host_end do together
// - Host repeats X_RDY, waits R_RDY before SOF
// - Device answers X_RDY with R_RDY until SOF
// - Device sends R_IP, stores DWORDs one behind
// - HOLD answered by HOLDA; data resumes R_IP
// - CRC is one DWORD before EOF
// - Host sends WTRM until result; R_OK delivered
// - After EOF check CRC, release, send R_OK
// - R_OK held until SYNC, then SYNC idle
// - Device may end DMA frame with DMAT
// - Host on DMAT sends CRC, EOF, WTRM
// - CRC covers data DWORDs, not primitives
// - CRC on unscrambled contents both ends
// - CRC per DWORD, odd half zero-padded
// - CRC sits on a DWORD boundary
// - CRC uses the 32-bit generator polynomial
// - CRC seeded 52325032h at each frame
// - Frame at most 2064 DWORDs, longer flagged
// - Failed check answers R_ERR instead
// - Idle link carries SYNC; handshake first
// - Host keeps WTRM awaiting R_OK or R_ERR
module sfl_dev_end
	import sfl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	sfl_link_if.dev lnk,
	input wire logic dmat_req,
	output logic [31:0] rx_data_ff,
	output logic rx_valid_ff,
	output logic frame_ok_ff,
	output logic frame_err_ff,
	output logic too_long_ff
);
	typedef enum logic [2:0] {
		D_IDLE, D_RDY, D_RCV, D_HOLDA, D_CHK, D_GOOD, D_BAD
	} dev_state_t;

	dev_state_t state_ff;
	dev_state_t nxt_state;
	prim_t d2h_ff;
	prim_t nxt_d2h;
	logic dmat_sent_ff;
	logic [31:0] pend_ff;
	logic pend_vld_ff;
	logic [DW_CNT_W-1:0] cnt_ff;
	logic [31:0] crc_ff;
	logic in_frame;
	logic word_in;
	logic sof_in;
	logic crc_good;

	assign lnk.d2h_prim = d2h_ff;

	assign in_frame = (state_ff == D_RCV) || (state_ff == D_HOLDA);
	// Primitives inside the frame never reach the CRC
	assign word_in = in_frame && !lnk.h2d_k;
	assign sof_in = (state_ff == D_RDY) && lnk.h2d_k &&
		(lnk.h2d_prim == P_SOF);
	// The last stored DWORD before EOF is the CRC itself
	assign crc_good = pend_vld_ff && (crc_ff == pend_ff) &&
		!too_long_ff;

	sfl_crc32 u_crc (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.init(sof_in),
		.en(word_in && pend_vld_ff),
		.data(pend_ff),
		.crc_ff(crc_ff)
	);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			D_IDLE: begin
				if (lnk.h2d_k && lnk.h2d_prim == P_X_RDY) begin
					nxt_state = D_RDY;
				end
			end
			D_RDY: begin
				if (lnk.h2d_k && lnk.h2d_prim == P_SOF) begin
					nxt_state = D_RCV;
				end else if (lnk.h2d_k && lnk.h2d_prim == P_SYNC) begin
					// Host withdrew its request before the frame began
					nxt_state = D_IDLE;
				end
			end
			D_RCV, D_HOLDA: begin
				if (!lnk.h2d_k) begin
					nxt_state = D_RCV;
				end else if (lnk.h2d_prim == P_HOLD) begin
					nxt_state = D_HOLDA;
				end else if (lnk.h2d_prim == P_EOF) begin
					nxt_state = D_CHK;
				end else if (lnk.h2d_prim == P_SYNC) begin
					// Host abort drops the frame
					nxt_state = D_IDLE;
				end
			end
			D_CHK: begin
				nxt_state = crc_good ? D_GOOD : D_BAD;
			end
			D_GOOD, D_BAD: begin
				if (lnk.h2d_k && lnk.h2d_prim == P_SYNC) begin
					nxt_state = D_IDLE;
				end
			end
			default: nxt_state = D_IDLE;
		endcase
	end

	always_comb begin
		case (nxt_state)
			D_IDLE: nxt_d2h = P_SYNC;
			D_RDY: nxt_d2h = P_R_RDY;
			D_RCV: begin
				// One DMAT per frame, only once payload is flowing
				if (dmat_req && !dmat_sent_ff && state_ff == D_RCV) begin
					nxt_d2h = P_DMAT;
				end else begin
					nxt_d2h = P_R_IP;
				end
			end
			D_HOLDA: nxt_d2h = P_HOLDA;
			// One compare cycle; R_IP tells the host the verdict is pending
			D_CHK: nxt_d2h = P_R_IP;
			D_GOOD: nxt_d2h = P_R_OK;
			D_BAD: nxt_d2h = P_R_ERR;
			default: nxt_d2h = P_SYNC;
		endcase
	end

	// The line symbol is registered so the host sees a clean primitive
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= D_IDLE;
			d2h_ff <= P_SYNC;
		end else begin
			state_ff <= nxt_state;
			d2h_ff <= nxt_d2h;
		end
	end

	// Remembers the one DMAT allowed per frame until the frame ends
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			dmat_sent_ff <= 1'b0;
		end else if (nxt_d2h == P_DMAT) begin
			dmat_sent_ff <= 1'b1;
		end else if (nxt_state != D_RCV && nxt_state != D_HOLDA) begin
			dmat_sent_ff <= 1'b0;
		end
	end

	// Each DWORD is held back one slot so the CRC is never released
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pend_ff <= WORD_RESET;
			pend_vld_ff <= 1'b0;
			rx_data_ff <= WORD_RESET;
			rx_valid_ff <= 1'b0;
		end else begin
			rx_valid_ff <= 1'b0;
			if (sof_in) begin
				pend_vld_ff <= 1'b0;
			end else if (word_in) begin
				pend_ff <= lnk.h2d_data;
				pend_vld_ff <= 1'b1;
				if (pend_vld_ff) begin
					rx_data_ff <= pend_ff;
					rx_valid_ff <= 1'b1;
				end
			end
		end
	end

	// The count stops at the limit; later words still pass upward, but
	// the frame can then only end in R_ERR
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= CNT_RESET;
			too_long_ff <= 1'b0;
		end else if (sof_in) begin
			cnt_ff <= CNT_RESET;
			too_long_ff <= 1'b0;
		end else if (word_in) begin
			if (cnt_ff == MAX_FRAME_DW) begin
				too_long_ff <= 1'b1;
			end else begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	// Result pulses rise with the first R_OK or R_ERR, so the upper layer
	// owns the frame before the host can hear the verdict
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			frame_ok_ff <= 1'b0;
			frame_err_ff <= 1'b0;
		end else begin
			frame_ok_ff <= (state_ff == D_CHK) && crc_good;
			frame_err_ff <= (state_ff == D_CHK) && !crc_good;
		end
	end
endmodule : sfl_dev_end

// >>> logic/sfl_host_end.sv
`timescale 1ns/1ps
module sfl_host_end
	import sfl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	sfl_link_if.host lnk,
	input wire logic tx_req,
	input wire logic tx_valid,
	input wire logic [31:0] tx_data,
	input wire logic tx_last,
	input wire logic tx_half,
	output logic tx_ready_ff,
	output logic done_ok_ff,
	output logic done_err_ff
);
	typedef enum logic [2:0] {
		H_IDLE, H_XRDY, H_DATA, H_HOLD, H_CRC, H_EOF, H_WAIT
	} host_state_t;

	host_state_t st_ff;
	logic hk_ff;
	prim_t hp_ff;
	logic [31:0] hd_ff;
	logic [31:0] crc_ff;
	logic taken;
	logic crc_init;
	logic [31:0] tx_word;

	assign lnk.h2d_k = hk_ff;
	assign lnk.h2d_prim = hp_ff;
	assign lnk.h2d_data = hd_ff;

	assign taken = tx_valid && tx_ready_ff && (st_ff == H_DATA);
	assign crc_init = (st_ff == H_XRDY) && (lnk.d2h_prim == P_R_RDY);
	// Odd trailing half word goes out and into the CRC zero-extended
	assign tx_word = (tx_last && tx_half) ?
		{PAD_HALF, tx_data[15:0]} : tx_data;

	sfl_crc32 u_crc (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.init(crc_init),
		.en(taken),
		.data(tx_word),
		.crc_ff(crc_ff)
	);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= H_IDLE;
			hk_ff <= 1'b1;
			hp_ff <= P_SYNC;
			hd_ff <= WORD_RESET;
			tx_ready_ff <= 1'b0;
		end else begin
			case (st_ff)
				H_IDLE: begin
					hk_ff <= 1'b1;
					hp_ff <= P_SYNC;
					if (tx_req) begin
						hp_ff <= P_X_RDY;
						st_ff <= H_XRDY;
					end
				end
				H_XRDY: begin
					if (lnk.d2h_prim == P_R_RDY) begin
						hp_ff <= P_SOF;
						tx_ready_ff <= 1'b1;
						st_ff <= H_DATA;
					end
				end
				H_DATA: begin
					if (taken) begin
						hk_ff <= 1'b0;
						hd_ff <= tx_word;
					end
					if (lnk.d2h_prim == P_DMAT || (taken && tx_last)) begin
						tx_ready_ff <= 1'b0;
						if (taken) begin
							st_ff <= H_CRC;
						end else begin
							hk_ff <= 1'b0;
							hd_ff <= crc_ff;
							st_ff <= H_EOF;
						end
					end else if (!taken) begin
						// Starved source pauses the frame
						hk_ff <= 1'b1;
						hp_ff <= P_HOLD;
						tx_ready_ff <= 1'b0;
						st_ff <= H_HOLD;
					end
				end
				H_HOLD: begin
					if (lnk.d2h_prim == P_DMAT) begin
						hk_ff <= 1'b0;
						hd_ff <= crc_ff;
						st_ff <= H_EOF;
					end else if (lnk.d2h_prim == P_HOLDA) begin
						tx_ready_ff <= 1'b1;
						st_ff <= H_DATA;
					end
				end
				H_CRC: begin
					hk_ff <= 1'b0;
					hd_ff <= crc_ff;
					st_ff <= H_EOF;
				end
				H_EOF: begin
					hk_ff <= 1'b1;
					hp_ff <= P_EOF;
					st_ff <= H_WAIT;
				end
				H_WAIT: begin
					hp_ff <= P_WTRM;
					if (lnk.d2h_prim == P_R_OK ||
						lnk.d2h_prim == P_R_ERR) begin
						hp_ff <= P_SYNC;
						st_ff <= H_IDLE;
					end
				end
				default: st_ff <= H_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			done_ok_ff <= 1'b0;
			done_err_ff <= 1'b0;
		end else begin
			done_ok_ff <= (st_ff == H_WAIT) &&
				(lnk.d2h_prim == P_R_OK);
			done_err_ff <= (st_ff == H_WAIT) &&
				(lnk.d2h_prim == P_R_ERR);
		end
	end
endmodule : sfl_host_end

// >>> test/serial_frame_link_crc_chk.sv
`timescale 1ns/1ps
module serial_frame_link_crc_chk
	import sfl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic h2d_k,
	input wire prim_t h2d_prim,
	input wire logic [31:0] h2d_data,
	input wire prim_t d2h_prim
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	wire h_sync = h2d_k && h2d_prim == P_SYNC;
	wire h_xrdy = h2d_k && h2d_prim == P_X_RDY;
	wire h_hold = h2d_k && h2d_prim == P_HOLD;
	wire h_eof = h2d_k && h2d_prim == P_EOF;
	wire h_wtrm = h2d_k && h2d_prim == P_WTRM;
	wire d_res = d2h_prim == P_R_OK || d2h_prim == P_R_ERR;

	a_rdy_answer: assert property (h_xrdy && d2h_prim == P_SYNC |=>
		d2h_prim == P_R_RDY) else $error("X_RDY not answered");
	a_rdy_held: assert property (h_xrdy && d2h_prim == P_R_RDY |=>
		d2h_prim == P_R_RDY) else $error("R_RDY dropped early");
	a_sof_after_rdy: assert property (h2d_k && h2d_prim == P_SOF |->
		d2h_prim == P_R_RDY && $past(d2h_prim) == P_R_RDY)
		else $error("SOF before R_RDY decoded");
	a_hold_ack: assert property (h_hold && d2h_prim == P_R_IP |=>
		d2h_prim == P_HOLDA) else $error("HOLD not acknowledged");
	a_holda_kept: assert property (h_hold && d2h_prim == P_HOLDA |=>
		d2h_prim == P_HOLDA) else $error("HOLDA dropped during HOLD");
	a_crc_before_eof: assert property (h_eof |-> !$past(h2d_k))
		else $error("EOF not preceded by CRC word");
	a_wtrm_wait: assert property (h_wtrm && !d_res |=> h_wtrm)
		else $error("WTRM left before result");
	a_result_bound: assert property (h_eof |-> ##[1:6] d_res)
		else $error("no result after EOF");
	a_ok_kept: assert property (d2h_prim == P_R_OK && !h_sync |=>
		d2h_prim == P_R_OK) else $error("R_OK dropped before SYNC");
	a_ok_release: assert property (d2h_prim == P_R_OK && h_sync |=>
		d2h_prim == P_SYNC) else $error("no SYNC after host release");
	a_dmat_single: assert property (d2h_prim == P_DMAT |=>
		d2h_prim != P_DMAT) else $error("DMAT held over two cycles");
	a_dmat_ends: assert property (d2h_prim == P_DMAT |-> ##[1:5] h_eof)
		else $error("frame not closed after DMAT");

	c_ok: cover property (d2h_prim == P_R_OK ##1 d2h_prim == P_SYNC);
	c_hold: cover property (d2h_prim == P_HOLDA);
	c_dmat: cover property (d2h_prim == P_DMAT);
	c_err: cover property (d2h_prim == P_R_ERR);
endmodule : serial_frame_link_crc_chk

// >>> test/serial_frame_link_crc_bench.sv
`timescale 1ns/1ps
module serial_frame_link_crc_bench
	import sfl_pkg::*;
;
	logic sys_clk = 0, nrst = 0, dmat_req = 0, tx_req = 0, tx_valid = 0;
	logic tx_last = 0, tx_half = 0, rx_valid_ff, frame_ok_ff, frame_err_ff;
	logic too_long_ff, tx_ready_ff, done_ok_ff, done_err_ff, err_b;
	logic [31:0] tx_data = 32'h0, rx_data_ff, last_d, crc_seen;
	logic [31:0] mem[0:2063];
	logic [31:0] rxq[$];
	int errors = 0, checked = 0, oks = 0, errs_b = 0, errs_a = 0;

	always #5 sys_clk = ~sys_clk;
	sfl_link_if i_sfl_link_if (.sys_clk(sys_clk), .nrst(nrst));
	sfl_link_if i_sfl_link_if_b (.sys_clk(sys_clk), .nrst(nrst));
	sfl_dev_end i_sfl_dev_end (.sys_clk(sys_clk), .nrst(nrst),
		.lnk(i_sfl_link_if), .dmat_req(dmat_req), .rx_data_ff(rx_data_ff),
		.rx_valid_ff(rx_valid_ff), .frame_ok_ff(frame_ok_ff),
		.frame_err_ff(frame_err_ff), .too_long_ff(too_long_ff));
	sfl_host_end i_sfl_host_end (.sys_clk(sys_clk), .nrst(nrst),
		.lnk(i_sfl_link_if), .tx_req(tx_req), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_half(tx_half),
		.tx_ready_ff(tx_ready_ff), .done_ok_ff(done_ok_ff),
		.done_err_ff(done_err_ff));
	// Second device faces the bench, which breaks the CRC on purpose
	sfl_dev_end i_sfl_dev_end_b (.sys_clk(sys_clk), .nrst(nrst),
		.lnk(i_sfl_link_if_b), .dmat_req(1'b0), .rx_data_ff(),
		.rx_valid_ff(), .frame_ok_ff(), .frame_err_ff(err_b),
		.too_long_ff());
	serial_frame_link_crc_chk i_chk (.sys_clk(sys_clk), .nrst(nrst),
		.h2d_k(i_sfl_link_if.h2d_k), .h2d_prim(i_sfl_link_if.h2d_prim),
		.h2d_data(i_sfl_link_if.h2d_data), .d2h_prim(i_sfl_link_if.d2h_prim));

	// Outputs are watched at the falling edge, where they have settled
	always @(negedge sys_clk) begin
		if (rx_valid_ff) rxq.push_back(rx_data_ff);
		if (frame_ok_ff) oks++;
		if (frame_err_ff) errs_a++;
		if (err_b) errs_b++;
		if (!i_sfl_link_if.h2d_k) last_d <= i_sfl_link_if.h2d_data;
		if (i_sfl_link_if.h2d_k && i_sfl_link_if.h2d_prim == P_EOF)
			crc_seen <= last_d;
	end

	function automatic logic [31:0] crc_step(logic [31:0] c, logic [31:0] d);
		for (int b = 31; b >= 0; b--)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ d[b]) ? 32'h04C11DB7 : 32'h0);
		return c;
	endfunction : crc_step

	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// Gap of three idle source cycles at word gap forces HOLD
	task automatic send(int n, bit half, int gap, bit dm, bit ok);
		int i = 0, g = 0, t = 0;
		logic [31:0] c = 32'h52325032;
		logic [31:0] w;
		logic take;
		rxq.delete();
		oks = 0;
		errs_a = 0;
		while (!(done_ok_ff || done_err_ff) && t < 3000) begin
			tx_req = i == 0;
			tx_valid = i < n && !(i == gap && g < 3);
			if (i == gap && g < 3) g++;
			tx_data = i < n ? mem[i] : 32'h0;
			tx_last = i == n - 1;
			tx_half = half && i == n - 1;
			dmat_req = dm && i >= 2;
			// Ready is settled here and holds until the edge that takes a word
			take = tx_valid && tx_ready_ff;
			@(posedge sys_clk);
			if (take) i++;
			@(negedge sys_clk);
			t++;
		end
		tx_valid = 0;
		dmat_req = 0;
		if (ok) begin
			chk("count", rxq.size(), i);
			for (int k = 0; k < i; k++) begin
				w = (half && k == n - 1) ? {16'h0000, mem[k][15:0]} : mem[k];
				chk("word", rxq[k], w);
				c = crc_step(c, w);
			end
			chk("crc", crc_seen, c);
		end
		chk("finished", done_ok_ff | done_err_ff, 1'b1);
		chk("done_ok", done_ok_ff, ok);
		chk("done_err", done_err_ff, !ok);
		chk("frame_ok", oks, ok);
		chk("frame_err", errs_a, !ok);
		chk("too_long", too_long_ff, !ok);
		repeat (4) @(negedge sys_clk);
		chk("idle", {i_sfl_link_if.h2d_k, i_sfl_link_if.h2d_prim,
			i_sfl_link_if.d2h_prim}, {1'b1, P_SYNC, P_SYNC});
		$display("test done: %0d words sent", i);
	endtask : send

	task automatic put(logic k, prim_t p, logic [31:0] d);
		@(negedge sys_clk);
		i_sfl_link_if_b.h2d_k = k;
		i_sfl_link_if_b.h2d_prim = p;
		i_sfl_link_if_b.h2d_data = d;
	endtask : put

	initial begin
		put(1'b1, P_SYNC, 32'h0);
		for (int k = 0; k < 2064; k++)
			mem[k] = {k[15:0] ^ 16'hA5C3, ~k[15:0]};
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		nrst = 1;
		send(2, 0, 99, 0, 1);
		send(5, 1, 1, 0, 1);
		send(9, 0, 99, 1, 1);
		put(1'b1, P_X_RDY, 32'h0);
		for (int t = 0; t < 8; t++)
			if (i_sfl_link_if_b.d2h_prim != P_R_RDY) put(1'b1, P_X_RDY, 32'h0);
		put(1'b1, P_SOF, 32'h0);
		put(1'b0, P_SYNC, 32'h1234ABCD);
		put(1'b0, P_SYNC, 32'hBAD0BAD0);
		put(1'b1, P_EOF, 32'h0);
		repeat (4) put(1'b1, P_WTRM, 32'h0);
		chk("err_pulse", errs_b, 1);
		chk("result", i_sfl_link_if_b.d2h_prim, P_R_ERR);
		repeat (3) put(1'b1, P_SYNC, 32'h0);
		chk("release", i_sfl_link_if_b.d2h_prim, P_SYNC);
		$display("test done: bad crc frame");
		send(2063, 0, 99, 0, 1);
		send(2064, 0, 99, 0, 0);
		end_sim();
	end

	initial begin
		#400000;
		errors++;
		end_sim();
	end
endmodule : serial_frame_link_crc_bench
